// file: rtl/lcdh_pkg.sv
`default_nettype none
package lcdh_pkg;

    // display address space
    localparam int PAGE_W = 6;
    localparam int COL_W = 8;
    localparam logic [5:0] PAGE_LAST = 6'h20;
    localparam logic [7:0] COL_LAST = 8'hB3;
    localparam logic [5:0] PAGE_RST = 6'h00;
    localparam logic [7:0] COL_RST = 8'h00;

    // serial receiver
    localparam int SER_BITS = 8;
    localparam logic [2:0] SER_CNT_LAST = 3'h7;
    localparam logic [2:0] SER_CNT_RST = 3'h0;

    // command that starts a serial status read; value is arbitrary
    localparam logic [7:0] STATUS_READ_CMD = 8'hD6;

    // fifo entry: {data_command_select, byte}
    localparam int ENTRY_W = 9;
    localparam int ENTRY_A0_BIT = 8;
    localparam int FIFO_DEPTH = 2;

    localparam logic [7:0] BYTE_RST = 8'h00;

    // pin synchroniser reset: deselected, strobes high, so no false edge
    localparam logic [5:0] CTL_IDLE = 6'h0B;

    typedef enum logic [3:0]
    {
        ST_IDLE = 4'h1,
        ST_WRITE = 4'h2,
        ST_READ = 4'h4,
        ST_RWAIT = 4'h8
    } lcdh_state_t;

endpackage
`default_nettype wire

// file: rtl/lcdh_host_port.sv
// What this block does
// - interface select high parallel, low serial
// - bus style high 68-style, low 80-style
// - decode data read, data write, command write
// - serial: 7-bit shifter, 3-bit counter, chip selected
// - serial data sampled rising edge, MSB first
// - eighth rising edge hands over one byte
// - select line sampled at every eighth edge
// - serial status read supported, own select handling
// - no display memory read in serial mode
// - chip deselect clears shifter and counter
// - deselected: bus released, strobes ignored
// - no wait states within host cycle time
// - data write held, committed before next
// - data read returns held value, reloads holder
// - address advances by one after access
`default_nettype none
module lcdh_host_port
#(
    parameter int DEPTH = lcdh_pkg::FIFO_DEPTH
)
(
    // system clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // host pins, parallel
    input wire logic mode_parallel_in,
    input wire logic bus_style_select_in,
    input wire logic chip_sel_b_in,
    input wire logic data_command_select_in,
    input wire logic strobe_rd_in,
    input wire logic strobe_wr_in,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_out,
    // host pins, serial
    input wire logic sclk_in,
    input wire logic sdata_in,
    output logic sdata_out,
    output logic sdata_oe_out,
    // command stream to the decoder
    output logic cmd_valid_out,
    input wire logic cmd_ready_in,
    output logic [7:0] cmd_byte_out,
    output logic cmd_is_param_out,
    input wire logic data_mode_in,
    input wire logic [7:0] status_in,
    output logic overrun_out,
    // display memory side
    input wire logic addr_load_in,
    input wire logic [5:0] addr_page_in,
    input wire logic [7:0] addr_col_in,
    input wire logic dir_page_in,
    output logic ram_we_out,
    output logic ram_rd_out,
    output logic [5:0] ram_page_out,
    output logic [7:0] ram_col_out,
    output logic [7:0] ram_wdata_out,
    input wire logic [7:0] ram_rdata_in
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    localparam int NCTL = 6;
    logic [NCTL-1:0] ctl_raw;
    logic [NCTL-1:0] ctl_s1_q;
    logic [NCTL-1:0] ctl_s2_q;
    logic [NCTL-1:0] ctl_s3_q;
    logic [7:0] din_s1_q;
    logic [7:0] din_s2_q;

    assign ctl_raw = {mode_parallel_in, bus_style_select_in, chip_sel_b_in,
                      data_command_select_in, strobe_rd_in, strobe_wr_in};

    genvar gi;
    generate
        for (gi = 0; gi < NCTL; gi++)
        begin : g_sync
            always_ff @(posedge mclk_in)
            begin
                if (!rst_b_in)
                begin
                    ctl_s1_q[gi] <= lcdh_pkg::CTL_IDLE[gi];
                    ctl_s2_q[gi] <= lcdh_pkg::CTL_IDLE[gi];
                    ctl_s3_q[gi] <= lcdh_pkg::CTL_IDLE[gi];
                end
                else
                begin
                    ctl_s1_q[gi] <= ctl_raw[gi];
                    ctl_s2_q[gi] <= ctl_s1_q[gi];
                    ctl_s3_q[gi] <= ctl_s2_q[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk_in)
    begin
        din_s1_q <= data_in;
        din_s2_q <= din_s1_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // parallel strobe decode

    logic par_mode;
    logic style68;
    logic cs_act;
    logic a0_now;
    logic rd_now;
    logic rd_prv;
    logic wr_now;
    logic wr_prv;
    logic par_wr;
    logic par_rd_start;
    logic par_rd_end;

    assign par_mode = ctl_s2_q[5];
    assign style68 = ctl_s2_q[4];
    assign cs_act = par_mode && !ctl_s3_q[3] && !ctl_s2_q[3];
    assign a0_now = ctl_s3_q[2];
    assign rd_now = ctl_s2_q[1];
    assign rd_prv = ctl_s3_q[1];
    assign wr_now = ctl_s2_q[0];
    assign wr_prv = ctl_s3_q[0];

    // 68-style: rd pin is enable, wr pin is read/write select
    always_comb
    begin
        if (style68)
        begin
            par_wr = cs_act && rd_prv && !rd_now && !wr_prv;
            par_rd_start = cs_act && !rd_prv && rd_now && wr_now;
            par_rd_end = cs_act && rd_prv && !rd_now && wr_prv;
        end
        else
        begin
            par_wr = cs_act && !wr_prv && wr_now;
            par_rd_start = cs_act && rd_prv && !rd_now;
            par_rd_end = cs_act && !rd_prv && rd_now;
        end
    end

    // read data: select high gives the holder, low the status byte
    logic [7:0] holder_q;
    logic [7:0] pdata_q;
    logic rd_act_q;

    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            pdata_q <= lcdh_pkg::BYTE_RST;
            rd_act_q <= 1'b0;
        end
        else
        begin
            if (par_rd_start)
            begin
                pdata_q <= a0_now ? holder_q : status_in;
                rd_act_q <= 1'b1;
            end
            if (par_rd_end || !cs_act)
                rd_act_q <= 1'b0;
        end
    end

    assign data_out = pdata_q;
    assign data_oe_out = rd_act_q;

    ////////////////////////////////////////////////////////////////////////////
    // serial receiver, link clock domain

    logic [6:0] sh_q;
    logic [2:0] cnt_q;
    logic [7:0] ser_byte_q;
    logic ser_a0_q;
    logic ser_tog_q;
    logic stat_arm_q;
    logic ser_last;

    assign ser_last = (cnt_q == lcdh_pkg::SER_CNT_LAST);

    // deselect is an asynchronous clear since the link clock may be stopped
    always_ff @(posedge sclk_in or posedge chip_sel_b_in)
    begin
        if (chip_sel_b_in)
        begin
            sh_q <= 7'h00;
            cnt_q <= lcdh_pkg::SER_CNT_RST;
        end
        else if (!mode_parallel_in)
        begin
            sh_q <= {sh_q[5:0], sdata_in};
            cnt_q <= cnt_q + 3'h1;
        end
    end

    // handover state survives deselect, so the toggle never double-counts
    always_ff @(posedge sclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            ser_byte_q <= lcdh_pkg::BYTE_RST;
            ser_a0_q <= 1'b0;
            ser_tog_q <= 1'b0;
            stat_arm_q <= 1'b0;
        end
        else if (!mode_parallel_in && !chip_sel_b_in && ser_last)
        begin
            ser_byte_q <= {sh_q, sdata_in};
            ser_a0_q <= data_command_select_in;
            ser_tog_q <= !ser_tog_q;
            // read armed by the command, cleared after eight bits out
            stat_arm_q <= !stat_arm_q && !data_command_select_in
                          && ({sh_q, sdata_in} == lcdh_pkg::STATUS_READ_CMD);
        end
    end

    // status shifted out on falling edges; status byte must be quasi-static
    logic [7:0] stat_q;
    logic so_q;

    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
            stat_q <= lcdh_pkg::BYTE_RST;
        else
            stat_q <= status_in;
    end

    always_ff @(negedge sclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            so_q <= 1'b0;
        else
            so_q <= stat_q[3'h7 - cnt_q];
    end

    assign sdata_out = so_q;
    assign sdata_oe_out = stat_arm_q;

    // byte event into the system clock domain
    logic tog_s1_q;
    logic tog_s2_q;
    logic tog_s3_q;
    logic ser_evt;

    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
        end
        else
        begin
            tog_s1_q <= ser_tog_q;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
        end
    end

    assign ser_evt = (tog_s2_q != tog_s3_q) && !par_mode;

    ////////////////////////////////////////////////////////////////////////////
    // two-entry buffer; host cannot be stalled, so a full buffer drops

    logic [lcdh_pkg::ENTRY_W-1:0] mem_q [DEPTH];
    logic [$clog2(DEPTH)-1:0] wp_q;
    logic [$clog2(DEPTH)-1:0] rp_q;
    logic [$clog2(DEPTH):0] cnt_f_q;
    logic push_req;
    logic push;
    logic pop;
    logic f_valid;
    logic f_ready;
    logic [lcdh_pkg::ENTRY_W-1:0] push_d;
    logic [lcdh_pkg::ENTRY_W-1:0] head;

    assign push_req = ser_evt || par_wr;
    assign push_d = par_mode ? {a0_now, din_s2_q} : {ser_a0_q, ser_byte_q};
    assign f_ready = (cnt_f_q != DEPTH[$clog2(DEPTH):0]);
    assign f_valid = (cnt_f_q != '0);
    assign push = push_req && f_ready;
    assign head = mem_q[rp_q];

    always_ff @(posedge mclk_in)
    begin
        if (push)
            mem_q[wp_q] <= push_d;
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_f_q <= '0;
            overrun_out <= 1'b0;
        end
        else
        begin
            if (push)
                wp_q <= wp_q + 1'b1;
            if (pop)
                rp_q <= rp_q + 1'b1;
            cnt_f_q <= cnt_f_q + {{$clog2(DEPTH){1'b0}}, push}
                               - {{$clog2(DEPTH){1'b0}}, pop};
            overrun_out <= push_req && !f_ready;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus holder and display memory access

    logic head_is_data;
    logic rd_pend_q;
    logic [5:0] page_q;
    logic [7:0] col_q;
    logic [5:0] page_nx;
    logic [7:0] col_nx;
    lcdh_pkg::lcdh_state_t st_q;

    assign head_is_data = head[lcdh_pkg::ENTRY_A0_BIT] && data_mode_in;
    assign cmd_valid_out = (st_q == lcdh_pkg::ST_IDLE) && f_valid && !head_is_data;
    assign cmd_byte_out = head[7:0];
    assign cmd_is_param_out = head[lcdh_pkg::ENTRY_A0_BIT];
    // an address load takes the idle cycle, so a data byte waits for the next
    assign pop = (st_q == lcdh_pkg::ST_IDLE) && f_valid
                 && (head_is_data ? !addr_load_in : cmd_ready_in);

    // wrap: last column steps the page, last page steps the column
    always_comb
    begin
        page_nx = page_q;
        col_nx = col_q;
        if (!dir_page_in)
        begin
            col_nx = (col_q == lcdh_pkg::COL_LAST) ? lcdh_pkg::COL_RST : col_q + 8'h01;
            if (col_q == lcdh_pkg::COL_LAST)
                page_nx = (page_q == lcdh_pkg::PAGE_LAST) ? lcdh_pkg::PAGE_RST
                                                           : page_q + 6'h01;
        end
        else
        begin
            page_nx = (page_q == lcdh_pkg::PAGE_LAST) ? lcdh_pkg::PAGE_RST : page_q + 6'h01;
            if (page_q == lcdh_pkg::PAGE_LAST)
                col_nx = (col_q == lcdh_pkg::COL_LAST) ? lcdh_pkg::COL_RST
                                                       : col_q + 8'h01;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
            rd_pend_q <= 1'b0;
        else if (par_rd_end && a0_now)
            rd_pend_q <= 1'b1;
        else if (st_q == lcdh_pkg::ST_READ)
            rd_pend_q <= 1'b0;
    end

    // buffered writes go first so a read sees every earlier write
    always_ff @(posedge mclk_in)
    begin
        if (!rst_b_in)
        begin
            st_q <= lcdh_pkg::ST_IDLE;
            holder_q <= lcdh_pkg::BYTE_RST;
            page_q <= lcdh_pkg::PAGE_RST;
            col_q <= lcdh_pkg::COL_RST;
        end
        else
        begin
            case (st_q)
                lcdh_pkg::ST_IDLE:
                begin
                    if (addr_load_in)
                    begin
                        page_q <= addr_page_in;
                        col_q <= addr_col_in;
                    end
                    else if (pop && head_is_data)
                    begin
                        holder_q <= head[7:0];
                        st_q <= lcdh_pkg::ST_WRITE;
                    end
                    else if (!f_valid && rd_pend_q)
                        st_q <= lcdh_pkg::ST_READ;
                end
                lcdh_pkg::ST_WRITE:
                begin
                    page_q <= page_nx;
                    col_q <= col_nx;
                    st_q <= lcdh_pkg::ST_IDLE;
                end
                lcdh_pkg::ST_READ:
                    st_q <= lcdh_pkg::ST_RWAIT;
                lcdh_pkg::ST_RWAIT:
                begin
                    holder_q <= ram_rdata_in;
                    page_q <= page_nx;
                    col_q <= col_nx;
                    st_q <= lcdh_pkg::ST_IDLE;
                end
                default:
                    st_q <= lcdh_pkg::ST_IDLE;
            endcase
        end
    end

    assign ram_we_out = (st_q == lcdh_pkg::ST_WRITE);
    assign ram_rd_out = (st_q == lcdh_pkg::ST_READ);
    assign ram_page_out = page_q;
    assign ram_col_out = col_q;
    assign ram_wdata_out = holder_q;

endmodule
`default_nettype wire

// file: verif/lcdh_host_port_asserts.sv
`default_nettype none
module lcdh_host_port_asserts
(
    // clock, reset and pins
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic mode_parallel_in,
    input wire logic chip_sel_b_in,
    input wire logic dir_page_in,
    input wire logic cmd_ready_in,
    // outputs watched
    input wire logic data_oe_out,
    input wire logic sdata_oe_out,
    input wire logic cmd_valid_out,
    input wire logic [7:0] cmd_byte_out,
    input wire logic cmd_is_param_out,
    input wire logic ram_we_out,
    input wire logic ram_rd_out,
    input wire logic [5:0] ram_page_out,
    input wire logic [7:0] ram_col_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    a_bus_released: assert property (chip_sel_b_in [*5] |-> !data_oe_out)
        else $error("bus driven while deselected");
    a_serial_no_read: assert property (!mode_parallel_in [*5] |-> !data_oe_out)
        else $error("bus driven in serial mode");
    a_oe_cause: assert property ($rose(data_oe_out) |->
        $past(chip_sel_b_in, 3) == 1'b0 && $past(mode_parallel_in, 3))
        else $error("bus driven without a selected read");
    a_col_step: assert property (ram_we_out && !dir_page_in &&
        ram_col_out != lcdh_pkg::COL_LAST |=> ram_col_out == $past(ram_col_out) + 8'h01
        && $stable(ram_page_out))
        else $error("column did not step");
    a_page_step: assert property (ram_we_out && dir_page_in &&
        ram_page_out != lcdh_pkg::PAGE_LAST |=> ram_page_out == $past(ram_page_out) + 6'h01
        && $stable(ram_col_out))
        else $error("page did not step");
    a_addr_wrap: assert property (ram_we_out && ram_col_out == lcdh_pkg::COL_LAST &&
        ram_page_out == lcdh_pkg::PAGE_LAST |=> ram_col_out == lcdh_pkg::COL_RST
        && ram_page_out == lcdh_pkg::PAGE_RST)
        else $error("address did not wrap");
    a_cmd_hold: assert property (cmd_valid_out && !cmd_ready_in |=> cmd_valid_out
        && $stable(cmd_byte_out) && $stable(cmd_is_param_out))
        else $error("stalled byte changed");
    a_we_single: assert property (ram_we_out |=> !ram_we_out)
        else $error("write pulse too long");
    a_status_mode: assert property (sdata_oe_out |-> !mode_parallel_in)
        else $error("serial out armed in parallel mode");
endmodule

bind lcdh_host_port lcdh_host_port_asserts u_chk (.*);
`default_nettype wire

// file: verif/lcdh_host_model.sv
`default_nettype none
module lcdh_host_model
(
    // clock and answers
    input wire logic mclk_in,
    input wire logic [7:0] rd_in,
    input wire logic oe_in,
    input wire logic sd_in,
    // host pins
    output logic par_out,
    output logic style_out,
    output logic cs_b_out,
    output logic dcs_out,
    output logic rd_out,
    output logic wr_out,
    output logic [7:0] d_out,
    output logic sclk_out,
    output logic sd_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        {par_out, style_out, cs_b_out, dcs_out, rd_out, wr_out} = 6'h3B;
        d_out = 8'h00;
        sclk_out = 1'b0;
        sd_out = 1'b0;
    end

    task automatic setup(input logic p, input logic s);
        @(negedge mclk_in);
        par_out = p;
        style_out = s;
        rd_out = !s;
        wr_out = 1'b1;
        repeat (4) @(negedge mclk_in);
    endtask

    // fixed timing, no wait: phases of 2, 6, 4 and 4 mclk keep the cycle-time minimum
    task automatic acc(input logic sel, input logic rw, input logic a0, input logic [7:0] d,
        output logic [7:0] q);
        @(negedge mclk_in);
        cs_b_out = !sel;
        dcs_out = a0;
        d_out = d;
        if (style_out) wr_out = rw;
        repeat (2) @(negedge mclk_in);
        if (style_out) rd_out = 1'b1;
        else if (rw) rd_out = 1'b0;
        else wr_out = 1'b0;
        repeat (6) @(negedge mclk_in);
        q = rd_in;
        rd_out = !style_out;
        // read/write select holds until the chip is released
        if (!style_out && !rw) wr_out = 1'b1;
        repeat (4) @(negedge mclk_in);
        cs_b_out = 1'b1;
        wr_out = 1'b1;
        // released bus shows the inverse so a stale byte never matches
        d_out = ~d;
        repeat (4) @(negedge mclk_in);
    endtask

    // link clock runs only inside the frame
    task automatic ser(input logic a0, input logic [7:0] b, input int n, output logic [7:0] q);
        @(negedge mclk_in);
        #7 cs_b_out = 1'b0;
        dcs_out = a0;
        for (int i = 7; i > 7 - n; i--)
        begin
            sd_out = b[i];
            #32 q[i] = sd_in;
            sclk_out = 1'b1;
            #32 sclk_out = 1'b0;
        end
        #16 sd_out = ~sd_out;
        cs_b_out = 1'b1;
        #400;
    endtask
endmodule
`default_nettype wire

// file: verif/lcdh_host_port_test.sv
`default_nettype none
module lcdh_host_port_test;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed
    {
        logic par;
        logic sty;
        logic a0;
        logic dm;
        logic dir;
        logic [7:0] b;
        logic [13:0] adr;
    } lcdh_row_t;

    logic mclk_in, rst_b_in, mode_parallel_in, bus_style_select_in, chip_sel_b_in;
    logic data_command_select_in, strobe_rd_in, strobe_wr_in, data_oe_out, sclk_in;
    logic sdata_in, sdata_out, sdata_oe_out, cmd_valid_out, cmd_ready_in, cmd_is_param_out;
    logic data_mode_in, overrun_out, addr_load_in, dir_page_in, ram_we_out, ram_rd_out;
    logic [7:0] data_in, data_out, cmd_byte_out, status_in, addr_col_in, ram_col_out;
    logic [7:0] ram_wdata_out, ram_rdata_in, host_d, q;
    logic [5:0] addr_page_in, ram_page_out;
    logic host_sd, ovf, oe_seen;
    logic [7:0] mem [0:16383];
    logic [8:0] cq [$];
    logic [21:0] wq [$];
    int failures = 0;
    int cmp_count = 0;
    lcdh_row_t r;
    lcdh_row_t rows [8] = '{
        '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'hEC, 14'h0000},
        '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h5A, 14'h0000},
        '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h3C, 14'h0000},
        '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 8'hA5, 14'h0000},
        '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 8'h96, 14'h0001},
        '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'hC3, 14'h0000},
        '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 8'h81, 14'h0101},
        '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h7E, 14'h0000}};

    assign data_in = data_oe_out ? data_out : host_d;
    assign sdata_in = sdata_oe_out ? sdata_out : host_sd;

    lcdh_host_port dut (.*);

    lcdh_host_model host
    (
        .mclk_in(mclk_in),
        .rd_in(data_out),
        .oe_in(data_oe_out),
        .sd_in(sdata_in),
        .par_out(mode_parallel_in),
        .style_out(bus_style_select_in),
        .cs_b_out(chip_sel_b_in),
        .dcs_out(data_command_select_in),
        .rd_out(strobe_rd_in),
        .wr_out(strobe_wr_in),
        .d_out(host_d),
        .sclk_out(sclk_in),
        .sd_out(host_sd)
    );

    initial
    begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end

    always @(posedge mclk_in)
    begin
        if (ram_we_out) mem[{ram_page_out, ram_col_out}] <= ram_wdata_out;
        if (ram_we_out) wq.push_back({ram_page_out, ram_col_out, ram_wdata_out});
        if (ram_rd_out) ram_rdata_in <= mem[{ram_page_out, ram_col_out}];
        if (cmd_valid_out && cmd_ready_in) cq.push_back({cmd_is_param_out, cmd_byte_out});
        if (overrun_out) ovf <= 1'b1;
        if (data_oe_out) oe_seen <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [21:0] got, input logic [21:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_q(input logic ram, input logic [21:0] e);
        chk(22'(ram ? wq.size() != 0 : cq.size() != 0), 22'h1);
        if (ram && wq.size() != 0) chk(wq.pop_front(), e);
        if (!ram && cq.size() != 0) chk(22'(cq.pop_front()), e);
    endtask

    task automatic load(input logic [13:0] a);
        @(negedge mclk_in);
        {addr_page_in, addr_col_in} = a;
        addr_load_in = 1'b1;
        @(negedge mclk_in);
        addr_load_in = 1'b0;
    endtask

    initial
    begin
        #400000;
        failures++;
        end_sim();
    end

    initial
    begin
        {rst_b_in, cmd_ready_in, data_mode_in, addr_load_in, dir_page_in, ovf, oe_seen} = 7'h20;
        status_in = 8'h4B;
        {addr_page_in, addr_col_in} = 14'h0000;
        ram_rdata_in = 8'h00;
        repeat (10) @(negedge mclk_in);
        chk(22'({cmd_valid_out, ram_we_out, ram_rd_out, data_oe_out, sdata_oe_out,
            overrun_out, ram_page_out, ram_col_out}), 22'h0);
        rst_b_in = 1'b1;
        repeat (5) @(negedge mclk_in);
        load(14'h0000);
        $display("reset test done");
        foreach (rows[i])
        begin
            r = rows[i];
            data_mode_in = r.dm;
            dir_page_in = r.dir;
            host.setup(r.par, r.sty);
            if (r.par) host.acc(1'b1, 1'b0, r.a0, r.b, q);
            else host.ser(r.a0, r.b, 8, q);
            repeat (8) @(negedge mclk_in);
            chk_q(r.a0 && r.dm, r.a0 && r.dm ? {r.adr, r.b} : 22'({r.a0, r.b}));
            $display("row %0d done", i);
        end
        host.setup(1'b1, 1'b0);
        data_mode_in = 1'b1;
        load(14'h0000);
        host.acc(1'b1, 1'b1, 1'b1, 8'h00, q);
        host.acc(1'b1, 1'b1, 1'b1, 8'h00, q);
        chk(22'(q), 22'h0000A5);
        host.setup(1'b1, 1'b1);
        host.acc(1'b1, 1'b1, 1'b1, 8'h00, q);
        chk(22'(q), 22'h000096);
        host.acc(1'b1, 1'b1, 1'b0, 8'h00, q);
        chk(22'(q), 22'h00004B);
        $display("read test done");
        oe_seen = 1'b0;
        host.acc(1'b0, 1'b1, 1'b1, 8'h00, q);
        host.acc(1'b0, 1'b0, 1'b0, 8'h11, q);
        host.setup(1'b0, 1'b0);
        host.acc(1'b1, 1'b1, 1'b1, 8'h00, q);
        chk(22'({oe_seen, cq.size() == 0, wq.size() == 0}), 22'h3);
        // partial frame must not shift the next byte
        host.ser(1'b0, 8'hE0, 3, q);
        host.ser(1'b0, 8'h35, 8, q);
        repeat (8) @(negedge mclk_in);
        chk_q(1'b0, 22'h035);
        $display("deselect test done");
        host.setup(1'b1, 1'b0);
        cmd_ready_in = 1'b0;
        for (int k = 0; k < 3; k++)
            host.acc(1'b1, 1'b0, 1'b0, 8'h21 + 8'(k), q);
        chk(22'({ovf, cmd_valid_out}), 22'h3);
        cmd_ready_in = 1'b1;
        repeat (6) @(negedge mclk_in);
        chk_q(1'b0, 22'h021);
        chk_q(1'b0, 22'h022);
        chk(22'(cq.size()), 22'h0);
        load(14'h20B3);
        host.acc(1'b1, 1'b0, 1'b1, 8'h5C, q);
        host.acc(1'b1, 1'b0, 1'b1, 8'h6D, q);
        repeat (8) @(negedge mclk_in);
        chk_q(1'b1, 22'h20B35C);
        chk_q(1'b1, 22'h00006D);
        $display("buffer and wrap test done");
        host.setup(1'b0, 1'b0);
        host.ser(1'b0, lcdh_pkg::STATUS_READ_CMD, 8, q);
        host.ser(1'b1, 8'h00, 8, q);
        chk(22'(q), 22'h00004B);
        $display("serial status test done");
        end_sim();
    end
endmodule
`default_nettype wire
